/* File: rtl/swsr_defines.svh */
// Timing counts, widths and reset values for the single-wire sensor readout.
`ifndef SWSR_DEFINES_SVH
`define SWSR_DEFINES_SVH

// ==========================================================================
// Clock rate
// ==========================================================================
`define SWSR_CLK_MHZ 20

// ==========================================================================
// Line timing in microseconds, and the derived counts of core_clk cycles
// ==========================================================================
`define SWSR_START_MIN_US 800
`define SWSR_START_MIN_CYC (`SWSR_START_MIN_US * `SWSR_CLK_MHZ)
`define SWSR_TURN_US 30
`define SWSR_TURN_CYC (`SWSR_TURN_US * `SWSR_CLK_MHZ)
`define SWSR_RESP_LOW_US 80
`define SWSR_RESP_LOW_CYC (`SWSR_RESP_LOW_US * `SWSR_CLK_MHZ)
`define SWSR_RESP_HIGH_US 80
`define SWSR_RESP_HIGH_CYC (`SWSR_RESP_HIGH_US * `SWSR_CLK_MHZ)
`define SWSR_BIT_LOW_US 50
`define SWSR_BIT_LOW_CYC (`SWSR_BIT_LOW_US * `SWSR_CLK_MHZ)
`define SWSR_ZERO_HIGH_US 27
`define SWSR_ZERO_HIGH_CYC (`SWSR_ZERO_HIGH_US * `SWSR_CLK_MHZ)
`define SWSR_ONE_HIGH_US 70
`define SWSR_ONE_HIGH_CYC (`SWSR_ONE_HIGH_US * `SWSR_CLK_MHZ)
`define SWSR_END_LOW_US 50
`define SWSR_END_LOW_CYC (`SWSR_END_LOW_US * `SWSR_CLK_MHZ)

// ==========================================================================
// Widths and reset values
// ==========================================================================
`define SWSR_TMR_W 20
`define SWSR_FRAME_BITS 40
`define SWSR_BITCNT_W 6
`define SWSR_WORD_W 16
`define SWSR_FIFO_DEPTH 16
`define SWSR_MEAS_RESET 16'h0000

`endif

/* File: rtl/swsr_pkg.sv */
// Types shared by the single-wire sensor readout design.
`include "swsr_defines.svh"

package swsr_pkg;

   // Frame engine states.
   typedef enum logic [3:0] {
      ST_SLEEP,
      ST_START_LOW,
      ST_TURN,
      ST_RESP_LOW,
      ST_RESP_HIGH,
      ST_BIT_LOW,
      ST_BIT_HIGH,
      ST_END_LOW,
      ST_MEASURE
   } swsr_state_e;

   typedef logic [`SWSR_TMR_W-1:0] swsr_tmr_t;
   typedef logic [`SWSR_WORD_W-1:0] swsr_word_t;

endpackage

/* File: rtl/swsr_sensor.sv */
// Device end of the single-wire sensor readout link with its measurement FIFO.
`timescale 1ns/100ps
`default_nettype none
`include "swsr_defines.svh"

// ==========================================================================
// Measurement FIFO
// ==========================================================================
// Synchronous FIFO; room and empty are registered, so ready leaves straight from a flop.
module swsr_fifo #(
   parameter int WIDTH = `SWSR_WORD_W,
   parameter int DEPTH = `SWSR_FIFO_DEPTH
) (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = AW + 1;

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wrPtr_ff;
   logic [AW-1:0] nxt_wrPtr;
   logic [AW-1:0] rdPtr_ff;
   logic [AW-1:0] nxt_rdPtr;
   logic [CW-1:0] count_ff;
   logic [CW-1:0] nxt_count;
   logic room_ff;
   logic nxt_room;
   logic empty_ff;
   logic nxt_empty;
   logic doWr;
   logic doRd;
   // Pointer and occupancy bookkeeping; pointers wrap because the depth is a power of two.
   always_comb begin
      doWr = inValid && room_ff;
      doRd = outReady && !empty_ff;
      nxt_wrPtr = wrPtr_ff + AW'(doWr);
      nxt_rdPtr = rdPtr_ff + AW'(doRd);
      nxt_count = count_ff + CW'(doWr) - CW'(doRd);
      nxt_room = (nxt_count != CW'(DEPTH));
      nxt_empty = (nxt_count == '0);
   end
   // Bookkeeping registers.
   always_ff @(posedge core_clk) begin
      if (reset) begin
         wrPtr_ff <= '0;
         rdPtr_ff <= '0;
         count_ff <= '0;
         room_ff <= 1'b1;
         empty_ff <= 1'b1;
      end else begin
         wrPtr_ff <= nxt_wrPtr;
         rdPtr_ff <= nxt_rdPtr;
         count_ff <= nxt_count;
         room_ff <= nxt_room;
         empty_ff <= nxt_empty;
      end
   end
   // Storage needs no reset; only entries below the count are ever read.
   always_ff @(posedge core_clk) begin
      if (doWr) begin
         mem[wrPtr_ff] <= inData;
      end
   end
   assign inReady = room_ff;
   assign outValid = !empty_ff;
   assign outData = mem[rdPtr_ff];
   // Occupancy never leaves its range and the flags agree with it.
   fifoFlags_a: assert property (@(posedge core_clk) disable iff (reset)
      (count_ff <= CW'(DEPTH)) && (room_ff == (count_ff != CW'(DEPTH))) && (empty_ff == (count_ff == '0)))
      else $error("FIFO occupancy and flags disagree");

endmodule

// ==========================================================================
// Frame engine
// ==========================================================================
module swsr_sensor
   import swsr_pkg::*;
#(
   parameter int unsigned START_MIN_CYC = `SWSR_START_MIN_CYC,
   parameter int unsigned CYC_PER_US = `SWSR_CLK_MHZ // Clock cycles per microsecond; a bench may shorten it.
) (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic lineIn,
   output logic lineOut,
   output logic lineOe,
   input wire logic measValid,
   output logic measReady,
   input wire logic [`SWSR_WORD_W-1:0] measData,
   output logic measReq,
   output logic asleep
);
   localparam swsr_tmr_t StartLim = swsr_tmr_t'(START_MIN_CYC - 1); // The timer lags the low time by one.
   localparam swsr_tmr_t TurnLim = swsr_tmr_t'(`SWSR_TURN_US * CYC_PER_US - 1);
   localparam swsr_tmr_t RespLowLim = swsr_tmr_t'(`SWSR_RESP_LOW_US * CYC_PER_US - 1);
   localparam swsr_tmr_t RespHighLim = swsr_tmr_t'(`SWSR_RESP_HIGH_US * CYC_PER_US - 1);
   localparam swsr_tmr_t BitLowLim = swsr_tmr_t'(`SWSR_BIT_LOW_US * CYC_PER_US - 1);
   localparam swsr_tmr_t ZeroHighLim = swsr_tmr_t'(`SWSR_ZERO_HIGH_US * CYC_PER_US - 1);
   localparam swsr_tmr_t OneHighLim = swsr_tmr_t'(`SWSR_ONE_HIGH_US * CYC_PER_US - 1);
   localparam swsr_tmr_t EndLowLim = swsr_tmr_t'(`SWSR_END_LOW_US * CYC_PER_US - 1);
   localparam logic [`SWSR_BITCNT_W-1:0] LastBit = `SWSR_BITCNT_W'(`SWSR_FRAME_BITS - 1);
   swsr_state_e state_ff;
   swsr_state_e nxt_state;
   swsr_tmr_t timer_ff;
   swsr_tmr_t nxt_timer;
   logic [`SWSR_FRAME_BITS-1:0] frame_ff;
   logic [`SWSR_FRAME_BITS-1:0] nxt_frame;
   logic [`SWSR_BITCNT_W-1:0] bitCnt_ff;
   logic [`SWSR_BITCNT_W-1:0] nxt_bitCnt;
   swsr_word_t hum_ff;
   swsr_word_t nxt_hum;
   swsr_word_t temp_ff;
   swsr_word_t nxt_temp;
   logic word_ff;
   logic nxt_word;
   logic lineOe_ff;
   logic nxt_lineOe;
   logic lineOut_ff;
   logic measReq_ff;
   logic nxt_measReq;
   logic asleep_ff;
   logic fifoValid;
   logic fifoPop;
   swsr_word_t fifoData;
   logic [7:0] checkSum;
   swsr_tmr_t highLim;
   // The front end may deliver a measurement whenever the FIFO has room; the FIFO holds it until the frame ends.
   swsr_fifo #(
      .WIDTH(`SWSR_WORD_W),
      .DEPTH(`SWSR_FIFO_DEPTH)
   ) measFifo (
      .core_clk(core_clk),
      .reset(reset),
      .inValid(measValid),
      .inReady(measReady),
      .inData(measData),
      .outValid(fifoValid),
      .outReady(fifoPop),
      .outData(fifoData)
   );

   // Frame sequencer: start detection, answer, data bits, closing low and measurement store.
   always_comb begin
      nxt_state = state_ff;
      nxt_timer = (timer_ff == '1) ? timer_ff : timer_ff + swsr_tmr_t'(1);
      nxt_frame = frame_ff;
      nxt_bitCnt = bitCnt_ff;
      nxt_hum = hum_ff;
      nxt_temp = temp_ff;
      nxt_word = word_ff;
      nxt_measReq = 1'b0;
      fifoPop = 1'b0;
      checkSum = 8'(hum_ff[15:8] + hum_ff[7:0] + temp_ff[15:8] + temp_ff[7:0]);
      highLim = frame_ff[`SWSR_FRAME_BITS-1] ? OneHighLim : ZeroHighLim;
      case (state_ff)
         ST_SLEEP: begin
            // Only a low line can begin a start pulse; a high line is no event.
            if (!lineIn) begin
               nxt_state = ST_START_LOW;
            end
         end
         ST_START_LOW: begin
            // A low shorter than the minimum is a glitch and sends us back to sleep.
            if (lineIn) begin
               nxt_state = (timer_ff >= StartLim) ? ST_TURN : ST_SLEEP;
            end
         end
         ST_TURN: begin
            // The frame is latched here so that it stays fixed while it is sent.
            if (timer_ff == TurnLim) begin
               nxt_state = ST_RESP_LOW;
               nxt_frame = {hum_ff, temp_ff, checkSum};
            end
         end
         ST_RESP_LOW: begin
            if (timer_ff == RespLowLim) begin
               nxt_state = ST_RESP_HIGH;
            end
         end
         ST_RESP_HIGH: begin
            if (timer_ff == RespHighLim) begin
               nxt_state = ST_BIT_LOW;
               nxt_bitCnt = '0;
            end
         end
         ST_BIT_LOW: begin
            if (timer_ff == BitLowLim) begin
               nxt_state = ST_BIT_HIGH;
            end
         end
         ST_BIT_HIGH: begin
            // The high time carries the value of the most significant remaining bit.
            if (timer_ff == highLim) begin
               nxt_frame = {frame_ff[`SWSR_FRAME_BITS-2:0], 1'b0};
               nxt_bitCnt = bitCnt_ff + `SWSR_BITCNT_W'(1);
               nxt_state = (bitCnt_ff == LastBit) ? ST_END_LOW : ST_BIT_LOW;
            end
         end
         ST_END_LOW: begin
            if (timer_ff == EndLowLim) begin
               nxt_state = ST_MEASURE;
               nxt_measReq = 1'b1;
               nxt_word = 1'b0;
            end
         end
         ST_MEASURE: begin
            // Line activity is not watched here; a start during the store is lost.
            fifoPop = fifoValid;
            if (fifoValid && !word_ff) begin
               nxt_hum = fifoData;
               nxt_word = 1'b1;
            end else if (fifoValid) begin
               nxt_temp = fifoData;
               nxt_state = ST_SLEEP;
            end
         end
         default: begin
            nxt_state = ST_SLEEP;
         end
      endcase
      // Every state measures its own time from its first cycle.
      if (nxt_state != state_ff) begin
         nxt_timer = '0;
      end
      // Open drain: the line is only ever pulled low, high comes from the pull-up.
      nxt_lineOe = (nxt_state == ST_RESP_LOW) || (nxt_state == ST_BIT_LOW) || (nxt_state == ST_END_LOW);
   end

   // Sequencer registers.
   always_ff @(posedge core_clk) begin
      if (reset) begin
         state_ff <= ST_SLEEP;
         timer_ff <= '0;
         frame_ff <= '0;
         bitCnt_ff <= '0;
         hum_ff <= `SWSR_MEAS_RESET;
         temp_ff <= `SWSR_MEAS_RESET;
         word_ff <= 1'b0;
         lineOe_ff <= 1'b0;
         lineOut_ff <= 1'b0;
         measReq_ff <= 1'b0;
         asleep_ff <= 1'b1;
      end else begin
         state_ff <= nxt_state;
         timer_ff <= nxt_timer;
         frame_ff <= nxt_frame;
         bitCnt_ff <= nxt_bitCnt;
         hum_ff <= nxt_hum;
         temp_ff <= nxt_temp;
         word_ff <= nxt_word;
         lineOe_ff <= nxt_lineOe;
         lineOut_ff <= 1'b0;
         measReq_ff <= nxt_measReq;
         asleep_ff <= (nxt_state == ST_SLEEP);
      end
   end

   assign lineOut = lineOut_ff;
   assign lineOe = lineOe_ff;
   assign measReq = measReq_ff;
   assign asleep = asleep_ff;
   // ==========================================================================
   // Checks
   // ==========================================================================
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (reset);
   startLength_a: assert property (
      (state_ff == ST_TURN && $past(state_ff) == ST_START_LOW) |-> $past(timer_ff) >= StartLim)
      else $error("Start accepted before the minimum low time");
   ackLow_a: assert property (
      (state_ff == ST_RESP_HIGH && $past(state_ff) == ST_RESP_LOW) |-> $past(timer_ff) == RespLowLim)
      else $error("Answer low phase has the wrong length");
   ackHigh_a: assert property (
      (state_ff == ST_BIT_LOW && $past(state_ff) == ST_RESP_HIGH) |-> $past(timer_ff) == RespHighLim)
      else $error("Answer high phase has the wrong length");
   frameOrder_a: assert property (
      $rose(state_ff == ST_RESP_LOW) |-> frame_ff[`SWSR_FRAME_BITS-1:8] == {hum_ff, temp_ff})
      else $error("Frame bytes are not in humidity then temperature order");
   checkByte_a: assert property (
      (state_ff == ST_RESP_LOW) |-> frame_ff[7:0] ==
         8'(frame_ff[39:32] + frame_ff[31:24] + frame_ff[23:16] + frame_ff[15:8]))
      else $error("Check byte is not the sum of the data bytes");
   bitLow_a: assert property (
      (state_ff == ST_BIT_HIGH && $past(state_ff) == ST_BIT_LOW) |-> $past(timer_ff) == BitLowLim)
      else $error("Bit low phase has the wrong length");
   zeroHigh_a: assert property (
      ($past(state_ff) == ST_BIT_HIGH && state_ff != ST_BIT_HIGH && !$past(frame_ff[39]))
      |-> $past(timer_ff) == ZeroHighLim)
      else $error("Zero bit high phase has the wrong length");
   oneHigh_a: assert property (
      ($past(state_ff) == ST_BIT_HIGH && state_ff != ST_BIT_HIGH && $past(frame_ff[39]))
      |-> $past(timer_ff) == OneHighLim)
      else $error("One bit high phase has the wrong length");
   frameLength_a: assert property (
      (state_ff == ST_END_LOW && $past(state_ff) == ST_BIT_HIGH) |-> $past(bitCnt_ff) == LastBit)
      else $error("Frame did not carry forty bits");
   closeLow_a: assert property (
      $rose(state_ff == ST_MEASURE) |-> $past(timer_ff) == EndLowLim && !lineOe)
      else $error("Closing low has the wrong length or the line stays driven");
   lineDrive_a: assert property (
      lineOe == (state_ff inside {ST_RESP_LOW, ST_BIT_LOW, ST_END_LOW}) && !lineOut)
      else $error("Line driven outside a low phase");
   measureReq_a: assert property (
      $rose(state_ff == ST_MEASURE) |-> measReq ##1 !measReq)
      else $error("Measurement request is not a single pulse at frame end");
   sleepAfter_a: assert property (
      ($past(state_ff) == ST_MEASURE && state_ff != ST_MEASURE) |-> state_ff == ST_SLEEP && asleep)
      else $error("Device did not sleep after storing the measurement");

   frameDone_c: cover property ($rose(state_ff == ST_END_LOW));
   shortStart_c: cover property ($past(state_ff) == ST_START_LOW && state_ff == ST_SLEEP);
   measStored_c: cover property ($past(state_ff) == ST_MEASURE && state_ff == ST_SLEEP);
   fifoFull_c: cover property (!measReady);
endmodule

`default_nettype wire

/* File: verif/swsr_host_model.sv */
// Host-side model of the single-wire readout link: start pulse and frame capture.
`timescale 1ns/100ps
`default_nettype none
`include "swsr_defines.svh"

module swsr_host_model #(
   parameter int CYC_PER_US = `SWSR_CLK_MHZ
) (
   input wire logic core_clk,
   input wire logic lineLevel,
   output logic hostPull
);
   // ==========================================================================
   // Capture state
   // ==========================================================================
   // A stuck line must not hang a capture, so every phase is cut off here.
   localparam int PhaseLimit = 3000;
   // Split between zero and one high times, 48 us of core_clk.
   localparam int OneThreshold = 48 * CYC_PER_US;
   int respLow;
   int respHigh;
   int endLow;
   int lowLen[40];
   int highLen[40];
   logic [39:0] frameBits;
   logic checkOk;

   // The line is released until a start pulse is asked for.
   initial hostPull = 1'b0;

   // ==========================================================================
   // Line tasks
   // ==========================================================================
   // Counts the cycles the line keeps one level; the device sends no clock.
   task automatic measure(input logic lvl, output int n);
      n = 0;
      do begin
         @(posedge core_clk);
         #1;
         n++;
      end while (lineLevel === lvl && n < PhaseLimit);
   endtask

   // Pulls the line low for a number of cycles, then lets the pull-up restore it.
   task automatic pull_low(input int cycles);
      @(negedge core_clk);
      hostPull = 1'b1;
      repeat (cycles) @(negedge core_clk);
      hostPull = 1'b0;
   endtask

   // Captures answer, 40 bits and closing low; a long high phase is a one.
   task automatic read_frame();
      int turn;
      measure(1'b1, turn);
      measure(1'b0, respLow);
      measure(1'b1, respHigh);
      for (int i = 0; i < 40; i++) begin
         measure(1'b0, lowLen[i]);
         measure(1'b1, highLen[i]);
         frameBits[39-i] = (highLen[i] > OneThreshold);
      end
      measure(1'b0, endLow);
      checkOk = (frameBits[7:0] === 8'(frameBits[39:32] + frameBits[31:24] + frameBits[23:16]
         + frameBits[15:8]));
   endtask
endmodule
`default_nettype wire

/* File: verif/swsr_sensor_test.sv */
// Self-checking testbench for the device end of the single-wire sensor readout.
`timescale 1ns/100ps
`default_nettype none
`include "swsr_defines.svh"

`define CHK(what, exp, got) \
   begin \
      totalChecks++; \
      if ((got) !== (exp)) begin \
         mismatches++; \
         $display("BAD %s expected %0h seen %0h", what, exp, got); \
      end \
   end

module swsr_sensor_test
   import swsr_pkg::*;
;
   // ==========================================================================
   // Signals and instances
   // ==========================================================================
   // A short start threshold keeps the run short; expectations derive from it.
   localparam int StartMin = 40;
   // Four cycles per microsecond keep two whole frames well inside the run budget.
   localparam int CycPerUs = 4;
   localparam int OneHigh = `SWSR_ONE_HIGH_US * CycPerUs;
   localparam int ZeroHigh = `SWSR_ZERO_HIGH_US * CycPerUs;
   logic core_clk;
   logic reset = 1'b1;
   logic lineIn;
   logic lineOut;
   logic lineOe;
   logic measValid = 1'b0;
   logic measReady;
   swsr_word_t measData = '0;
   logic measReq;
   logic asleep;
   logic hostPull;
   int mismatches = 0;
   int totalChecks = 0;

   // Open-drain wire: either party pulls low, otherwise the pull-up wins.
   assign lineIn = (lineOe ? lineOut : 1'b1) & ~hostPull;

   swsr_sensor #(.START_MIN_CYC(StartMin), .CYC_PER_US(CycPerUs)) i_swsr_sensor (.core_clk(core_clk),
      .reset(reset), .lineIn(lineIn), .lineOut(lineOut), .lineOe(lineOe), .measValid(measValid),
      .measReady(measReady), .measData(measData), .measReq(measReq), .asleep(asleep));

   swsr_host_model #(.CYC_PER_US(CycPerUs)) i_swsr_host_model (.core_clk(core_clk), .lineLevel(lineIn),
      .hostPull(hostPull));

   // Free-running 20 MHz clock.
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end

   // ==========================================================================
   // Helpers
   // ==========================================================================
   // Prints the counts and the verdict, then stops the run.
   task automatic finishTest();
      $display("checks %0d mismatches %0d", totalChecks, mismatches);
      if (mismatches == 0 && totalChecks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // Offers one word and waits until the front-end handshake takes it; valid stays up.
   task automatic push_word(input swsr_word_t w);
      int n;
      n = 0;
      measData = w;
      measValid = 1'b1;
      while (measReady !== 1'b1 && n < 50) begin
         @(negedge core_clk);
         n++;
      end
      @(negedge core_clk);
   endtask

   // ==========================================================================
   // Scenarios
   // ==========================================================================
   // Fills the buffer to its refusal point; the first two words feed the second frame.
   task automatic test_fill();
      for (int i = 0; i < `SWSR_FIFO_DEPTH; i++) begin
         push_word((i == 0) ? 16'h0080 : (i == 1) ? 16'h8001 : 16'(16'h5A00 + i));
      end
      measValid = 1'b0;
      @(negedge core_clk);
      `CHK("full refuses", 1'b0, measReady)
      $display("test fill done");
   endtask

   // A start one cycle short must leave the device asleep and silent.
   task automatic test_short_start();
      int oeSeen;
      oeSeen = 0;
      i_swsr_host_model.pull_low(StartMin - 1);
      repeat (800) begin
         @(negedge core_clk);
         if (lineOe === 1'b1) oeSeen++;
      end
      `CHK("short start answer", 0, oeSeen)
      `CHK("short start sleep", 1'b1, asleep)
      $display("test short start done");
   endtask

   // Full transaction: answer, bit timing, order, check byte, close, re-measure, sleep.
   task automatic test_frame(input swsr_word_t hum, input swsr_word_t temp);
      logic [39:0] exp;
      int req;
      int oe;
      exp = {hum, temp, 8'(hum[15:8] + hum[7:0] + temp[15:8] + temp[7:0])};
      req = 0;
      oe = 0;
      i_swsr_host_model.pull_low(StartMin);
      i_swsr_host_model.read_frame();
      `CHK("answer low", `SWSR_RESP_LOW_US * CycPerUs, i_swsr_host_model.respLow)
      `CHK("answer high", `SWSR_RESP_HIGH_US * CycPerUs, i_swsr_host_model.respHigh)
      for (int i = 0; i < 40; i++) begin
         `CHK("bit low", `SWSR_BIT_LOW_US * CycPerUs, i_swsr_host_model.lowLen[i])
         `CHK("bit high", exp[39-i] ? OneHigh : ZeroHigh, i_swsr_host_model.highLen[i])
      end
      `CHK("frame bits", exp, i_swsr_host_model.frameBits)
      `CHK("check byte", 1'b1, i_swsr_host_model.checkOk)
      `CHK("closing low", `SWSR_END_LOW_US * CycPerUs, i_swsr_host_model.endLow)
      `CHK("awake", 1'b0, asleep)
      for (int k = 0; k < 200; k++) begin
         @(negedge core_clk);
         if (measReq === 1'b1) req++;
         if (lineOe === 1'b1) oe++;
         if (asleep === 1'b1) break;
      end
      `CHK("measure request", 1, req)
      `CHK("released", 0, oe)
      `CHK("asleep again", 1'b1, asleep)
      `CHK("words stored", 1'b1, measReady)
      $display("test frame %h done", exp);
   endtask

   // ==========================================================================
   // Main sequence and watchdog
   // ==========================================================================
   // Reset for three cycles, then each scenario in turn.
   initial begin
      repeat (3) @(negedge core_clk);
      reset = 1'b0;
      @(negedge core_clk);
      `CHK("idle release", 1'b0, lineOe)
      `CHK("idle line value", 1'b0, lineOut)
      `CHK("idle sleep", 1'b1, asleep)
      test_fill();
      test_short_start();
      test_frame(`SWSR_MEAS_RESET, `SWSR_MEAS_RESET);
      test_frame(16'h0080, 16'h8001);
      finishTest();
   end

   // Two frames take about 30000 cycles at this tick rate; well past that the run is stuck.
   initial begin
      repeat (60000) @(posedge core_clk);
      mismatches++;
      $display("BAD watchdog expected done seen hang");
      finishTest();
   end
endmodule
`default_nettype wire
